/* rtl/scs_pkg.sv */
// package: offsets, field layout, reset values and carriers for the system csr block
package scs_pkg;
   localparam logic [9:0]  SCS_OFF_IDENT     = 10'h050;
   localparam logic [9:0]  SCS_OFF_BYTE_ORD  = 10'h064;
   localparam logic [9:0]  SCS_OFF_VPHY_SCS  = 10'h1DC;
   localparam logic [9:0]  SCS_OFF_RST_CTRL  = 10'h1F8;
   localparam logic [31:0] SCS_BYTE_PATTERN  = 32'h87654321;
   localparam logic [15:0] SCS_CHIP_ID_DFLT  = 16'h0A5C;
   localparam logic [15:0] SCS_CHIP_REV_DFLT = 16'h0001;
   localparam logic [31:0] SCS_NOT_READY_VAL = 32'h00000000;
   localparam int          SCS_BIT_HBT       = 0;
   localparam int          SCS_BIT_SPD_LO    = 2;
   localparam int          SCS_BIT_SPD_HI    = 4;
   localparam int          SCS_BIT_CLK_STR   = 5;
   localparam int          SCS_BIT_CLK_DIR   = 6;
   localparam int          SCS_BIT_MODE_LO   = 8;
   localparam int          SCS_BIT_MODE_HI   = 9;
   localparam int          SCS_BIT_HIRATE    = 10;
   localparam int          SCS_BIT_LINK_RST  = 1;
   localparam logic [1:0]  SCS_MODE_MII_PHY  = 2'h1;

   typedef struct packed {
      logic        hirate;
      logic [1:0]  port0_mode;
      logic        refclk_dir;
      logic        clk_drive;
      logic        heartbeat_off;
   } scs_straps_s;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [9:0]  addr;
      logic [31:0] wdata;
   } scs_req_s;

   typedef struct packed {
      logic        autoneg_en;
      logic        speed_sel_low;
      logic        duplex_sel;
      logic        soft_reset;
      logic        an_done;
      logic        an_speed_100;
      logic        an_full_duplex;
   } scs_link_s;

   typedef struct packed {
      logic        hirate;
      logic [1:0]  port0_mode;
      logic        refclk_dir;
      logic        clk_drive;
      logic        heartbeat_off;
      logic        strap_taken;
      logic [31:0] rdata;
      logic        rvalid;
      logic        heartbeat_en;
   } scs_state_s;
endpackage

/* rtl/scs_system_csr.sv */
// system csr block: emulated link status/control, identity and byte order registers
`timescale 1ns/10ps
module scs_system_csr #(
   parameter logic [15:0] CHIP_ID  = scs_pkg::SCS_CHIP_ID_DFLT,  // any nonzero value
   parameter logic [15:0] CHIP_REV = scs_pkg::SCS_CHIP_REV_DFLT  // value arbitrary
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 ready_i,
   input  wire scs_pkg::scs_straps_s straps_i,
   input  wire scs_pkg::scs_req_s    req_i,
   input  wire logic                 half_i,
   input  wire logic                 half_sel_i,
   input  wire scs_pkg::scs_link_s   link_i,
   output logic [31:0]               rdata_o,
   output logic                      rvalid_o,
   output logic                      heartbeat_en_o,
   output logic                      hirate_o,
   output logic [1:0]                port0_mode_o,
   output logic                      refclk_dir_o,
   output logic                      clk_drive_o
);
   import scs_pkg::*;

   scs_state_s  s_q;
   scs_state_s  s_d;
   scs_straps_s strap_m_q;
   scs_straps_s strap_s_q;

   // a zero code could not be told apart from the not-ready read value
   if (CHIP_ID == 16'h0000)
   begin : g_bad_chip_id
      $error("chip id must be nonzero");
   end

   function automatic logic [2:0] spd_dup(input logic fast, input logic full);
      spd_dup = {full, fast, ~fast};
   endfunction

   function automatic logic [31:0] half_view(input logic [31:0] v, input logic h, input logic sel);
      if (!h)
      begin
         half_view = v;
      end
      else
      begin
         half_view = sel ? {16'h0000, v[31:16]} : {16'h0000, v[15:0]};
      end
   endfunction

   // straps come from pins: two flops before use; kept out of reset so they
   // already hold the strap levels when the first edge after release latches them
   always_ff @(posedge ref_clk_i)
   begin
      strap_m_q <= straps_i;
      strap_s_q <= strap_m_q;
   end

   logic [2:0]  spd_field;
   logic [31:0] scs_word;
   logic        wr_scs;
   logic        exempt_rst;

   always_comb
   begin
      spd_field = link_i.autoneg_en ? spd_dup(link_i.an_speed_100, link_i.an_full_duplex)
                                    : spd_dup(link_i.speed_sel_low, link_i.duplex_sel);
      scs_word = 32'h00000000;
      scs_word[SCS_BIT_HBT] = s_q.heartbeat_off;
      scs_word[SCS_BIT_SPD_HI:SCS_BIT_SPD_LO] = spd_field;
      scs_word[SCS_BIT_CLK_STR] = s_q.clk_drive;
      scs_word[SCS_BIT_CLK_DIR] = s_q.refclk_dir;
      scs_word[SCS_BIT_MODE_HI:SCS_BIT_MODE_LO] = s_q.port0_mode;
      scs_word[SCS_BIT_HIRATE] = s_q.hirate;
      wr_scs = req_i.wr && ready_i && (req_i.addr == SCS_OFF_VPHY_SCS);
      exempt_rst = req_i.wr && (req_i.addr == SCS_OFF_RST_CTRL) && req_i.wdata[SCS_BIT_LINK_RST];

      s_d = s_q;
      s_d.rvalid = req_i.rd;
      s_d.rdata = 32'h00000000;
      if (!s_q.strap_taken)
      begin
         // strap capture a cycle after release, once synchroniser settled
         s_d.strap_taken = 1'b1;
         s_d.hirate = strap_s_q.hirate;
         s_d.port0_mode = strap_s_q.port0_mode;
         s_d.refclk_dir = strap_s_q.refclk_dir;
         s_d.clk_drive = strap_s_q.clk_drive;
         s_d.heartbeat_off = strap_s_q.heartbeat_off;
      end
      else if (exempt_rst)
      begin
         s_d.refclk_dir = strap_s_q.refclk_dir;
         s_d.clk_drive = strap_s_q.clk_drive;
         s_d.heartbeat_off = strap_s_q.heartbeat_off;
         s_d.hirate = strap_s_q.hirate;
      end
      else if (link_i.soft_reset)
      begin
         s_d.hirate = strap_s_q.hirate;
      end
      else if (wr_scs)
      begin
         // only bits 0, 5, 6 and 10 are writable; mode and speed stay read-only
         s_d.heartbeat_off = req_i.wdata[SCS_BIT_HBT];
         s_d.clk_drive = req_i.wdata[SCS_BIT_CLK_STR];
         s_d.refclk_dir = req_i.wdata[SCS_BIT_CLK_DIR];
         s_d.hirate = req_i.wdata[SCS_BIT_HIRATE];
      end

      if (req_i.rd)
      begin
         case (req_i.addr)
            SCS_OFF_BYTE_ORD: s_d.rdata = half_view(SCS_BYTE_PATTERN, half_i, half_sel_i);
            SCS_OFF_IDENT:    s_d.rdata = ready_i ? half_view({CHIP_ID, CHIP_REV}, half_i, half_sel_i)
                                                  : SCS_NOT_READY_VAL;
            SCS_OFF_VPHY_SCS: s_d.rdata = ready_i ? (half_i ? {16'h0000, scs_word[15:0]} : scs_word)
                                                  : SCS_NOT_READY_VAL;
            default:          s_d.rdata = 32'h00000000;
         endcase
      end
      // port 0 mode gates the heartbeat test
      s_d.heartbeat_en = (s_d.port0_mode == SCS_MODE_MII_PHY) && !s_d.heartbeat_off;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_q <= '0;  // rdata zero during reset, never the pattern
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rdata_o        = s_q.rdata;
   assign rvalid_o       = s_q.rvalid;
   assign heartbeat_en_o = s_q.heartbeat_en;
   assign hirate_o       = s_q.hirate;
   assign port0_mode_o   = s_q.port0_mode;
   assign refclk_dir_o   = s_q.refclk_dir;
   assign clk_drive_o    = s_q.clk_drive;

   sequence s_byte_full_rd;
      req_i.rd && req_i.addr == SCS_OFF_BYTE_ORD && !half_i;
   endsequence

   a_byte_pattern_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_byte_full_rd |=> rvalid_o && rdata_o == SCS_BYTE_PATTERN)
      else $error("byte order pattern wrong");
   a_byte_notready_ok: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_i.rd && !ready_i && req_i.addr == SCS_OFF_BYTE_ORD && !half_i |=> rdata_o == 32'h87654321)
      else $error("byte order not served when not ready");
   a_byte_half_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_i.rd && req_i.addr == SCS_OFF_BYTE_ORD && half_i && half_sel_i |=> rdata_o == 32'h00008765)
      else $error("upper half wrong");
   a_ident_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_i.rd && ready_i && req_i.addr == SCS_OFF_IDENT && !half_i |=> rdata_o == {CHIP_ID, CHIP_REV})
      else $error("identity read wrong");
   a_scs_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_i.rd && req_i.addr == SCS_OFF_VPHY_SCS |=> rdata_o[31:16] == 16'h0000)
      else $error("padding bits nonzero");
   a_speed_field: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      req_i.rd && ready_i && req_i.addr == SCS_OFF_VPHY_SCS && !link_i.autoneg_en
      |=> rdata_o[4:2] == {$past(link_i.duplex_sel), $past(link_i.speed_sel_low), !$past(link_i.speed_sel_low)})
      else $error("speed field mirror wrong");
   a_heartbeat_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      heartbeat_en_o |-> port0_mode_o == SCS_MODE_MII_PHY && !s_q.heartbeat_off)
      else $error("heartbeat enabled outside phy mode");
   a_softrst_keeps: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_q.strap_taken && link_i.soft_reset && !exempt_rst
      |=> $stable(refclk_dir_o) && $stable(clk_drive_o) && $stable(s_q.heartbeat_off))
      else $error("soft reset touched exempt bits");
   a_exempt_default: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_q.strap_taken && exempt_rst |=> s_q.heartbeat_off == $past(strap_s_q.heartbeat_off))
      else $error("exempt bit not restored");
   a_hbt_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      s_q.strap_taken && wr_scs && !exempt_rst && !link_i.soft_reset
      |=> s_q.heartbeat_off == $past(req_i.wdata[0]))
      else $error("heartbeat write lost");
endmodule // scs_system_csr

/* tb/scs_host_model.sv */
// host model: drives the register request port and collects read answers
`timescale 1ns/10ps
module scs_host_model (
   input  wire logic        ref_clk_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic        rvalid_i,
   output scs_pkg::scs_req_s req_o,
   output logic             half_o,
   output logic             half_sel_o
);
   import scs_pkg::*;
   initial
   begin
      req_o      = '{rd: 1'b0, wr: 1'b0, addr: 10'h3FF, wdata: 32'hA5A5A5A5};
      half_o     = 1'b0;
      half_sel_o = 1'b0;
   end
   // released lines toggle so the block cannot lean on a stale value
   task automatic idle();
      req_o.rd    = 1'b0;
      req_o.wr    = 1'b0;
      req_o.addr  = ~req_o.addr;
      req_o.wdata = ~req_o.wdata;
   endtask
   task automatic rd(input logic [9:0] a, input logic hv, input logic hs, output logic [31:0] d);
      int n;
      @(negedge ref_clk_i);
      req_o.rd   = 1'b1;
      req_o.addr = a;
      half_o     = hv;
      half_sel_o = hs;
      @(negedge ref_clk_i);
      idle();
      for (n = 0; n < 4 && rvalid_i !== 1'b1; n++)
         @(negedge ref_clk_i);
      d      = (rvalid_i === 1'b1) ? rdata_i : 32'hXXXXXXXX;
      half_o = 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(negedge ref_clk_i);
      req_o.wr    = 1'b1;
      req_o.addr  = a;
      req_o.wdata = v;
      @(negedge ref_clk_i);
      idle();
      @(negedge ref_clk_i);
   endtask
endmodule // scs_host_model

/* tb/scs_system_csr_tb.sv */
// testbench: resets the block, then checks each register behaviour in turn
`timescale 1ns/10ps
module scs_system_csr_tb;
   import scs_pkg::*;
   logic              ref_clk_i = 1'b0;
   logic              rstn_i    = 1'b0;
   logic              ready_i   = 1'b0;
   scs_straps_s       straps_i  = '0;
   scs_link_s         link_i    = '0;
   scs_req_s          req;
   logic              half, half_sel, rvalid_o, heartbeat_en_o, hirate_o, refclk_dir_o, clk_drive_o;
   logic [1:0]        port0_mode_o;
   logic [31:0]       rdata_o, d;
   int                err_total   = 0;
   int                check_count = 0;
   wire  [5:0]        ctl = {hirate_o, port0_mode_o, refclk_dir_o, clk_drive_o, heartbeat_en_o};
   always #12.5 ref_clk_i = ~ref_clk_i;
   scs_system_csr uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ready_i(ready_i), .straps_i(straps_i),
      .req_i(req), .half_i(half), .half_sel_i(half_sel), .link_i(link_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .heartbeat_en_o(heartbeat_en_o), .hirate_o(hirate_o),
      .port0_mode_o(port0_mode_o), .refclk_dir_o(refclk_dir_o), .clk_drive_o(clk_drive_o));
   scs_host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req),
      .half_o(half), .half_sel_o(half_sel));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input scs_straps_s s);
      @(negedge ref_clk_i);
      rstn_i   = 1'b0;
      straps_i = s;
      repeat (3) @(negedge ref_clk_i);
      // a poll during reset must never come back as the valid pattern
      host.rd(SCS_OFF_BYTE_ORD, 1'b0, 1'b0, d);
      @(negedge ref_clk_i);
      chk({31'h0, d === SCS_BYTE_PATTERN}, 32'h0);
      chk(rdata_o, SCS_NOT_READY_VAL);
      rstn_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
   endtask
   task automatic t_not_ready();
      int n;
      ready_i = 1'b0;
      for (n = 0; n < 8 && d !== SCS_BYTE_PATTERN; n++)
         host.rd(SCS_OFF_BYTE_ORD, 1'b0, 1'b0, d);
      chk(d, SCS_BYTE_PATTERN);
      host.rd(SCS_OFF_IDENT, 1'b0, 1'b0, d);
      chk(d, 32'h0);
      host.wr(SCS_OFF_VPHY_SCS, 32'h1);
      ready_i = 1'b1;
      host.rd(SCS_OFF_VPHY_SCS, 1'b0, 1'b0, d);
      chk(d, 32'h104);
   endtask
   task automatic t_ident();
      host.rd(SCS_OFF_IDENT, 1'b0, 1'b0, d);
      chk(d, {SCS_CHIP_ID_DFLT, SCS_CHIP_REV_DFLT});
      host.wr(SCS_OFF_IDENT, 32'hFFFFFFFF);
      host.wr(SCS_OFF_BYTE_ORD, 32'h0);
      host.rd(SCS_OFF_IDENT, 1'b0, 1'b0, d);
      chk(d, {SCS_CHIP_ID_DFLT, SCS_CHIP_REV_DFLT});
      host.rd(SCS_OFF_BYTE_ORD, 1'b1, 1'b1, d);
      chk(d, 32'h8765);
      host.rd(SCS_OFF_BYTE_ORD, 1'b1, 1'b0, d);
      chk(d, 32'h4321);
      host.rd(SCS_OFF_VPHY_SCS, 1'b1, 1'b0, d);
      chk(d, 32'h104);
   endtask
   task automatic t_speed();
      logic [1:0] i;
      // slow half, fast half, slow full, fast full
      logic [2:0] enc [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
      for (int k = 0; k < 4; k++)
      begin
         i      = k[1:0];
         link_i = '{1'b0, i[0], i[1], 1'b0, 1'b1, ~i[0], ~i[1]};
         host.rd(SCS_OFF_VPHY_SCS, 1'b0, 1'b0, d);
         chk({29'h0, d[4:2]}, {29'h0, enc[k]});
         link_i = '{1'b1, ~i[0], ~i[1], 1'b0, 1'b1, i[0], i[1]};
         host.rd(SCS_OFF_VPHY_SCS, 1'b0, 1'b0, d);
         chk({29'h0, d[4:2]}, {29'h0, enc[k]});
      end
      link_i = '0;
   endtask
   task automatic t_controls();
      host.wr(SCS_OFF_VPHY_SCS, 32'h461);
      chk({26'h0, ctl}, 32'h2E);
      host.rd(SCS_OFF_VPHY_SCS, 1'b0, 1'b0, d);
      chk(d, 32'h565);
      link_i.soft_reset = 1'b1;
      @(negedge ref_clk_i);
      link_i.soft_reset = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      chk({26'h0, ctl}, 32'h0E);
      host.wr(SCS_OFF_RST_CTRL, 32'h2);
      chk({26'h0, ctl}, 32'h09);
   endtask
   // two further resets in mid-run; rmii mode must keep the heartbeat test off
   task automatic t_straps();
      do_reset(6'b110110);
      chk({26'h0, ctl}, 32'h36);
      do_reset(6'b001001);
      chk({26'h0, ctl}, 32'h08);
   endtask
   initial
   begin
      do_reset(6'b001000);
      t_not_ready();
      t_ident();
      t_speed();
      t_controls();
      t_straps();
      conclude();
   end
   initial
   begin
      #100000;
      err_total++;
      conclude();
   end
endmodule // scs_system_csr_tb
